/* File: shared/rsc_pkg.sv */
// Constants, register map and types of the reset source controller
package rsc_pkg;
    localparam int CLK_HZ = 250_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    localparam int LP_OSC_HZ = 1_000;
    localparam int LP_DIV_CYCLES = CLK_HZ / LP_OSC_HZ;
    localparam int FAST_OSC_HZ = 2_000_000;
    localparam int FAST_DIV_CYCLES = CLK_HZ / FAST_OSC_HZ;
    localparam int WDOG_HOLD_TICKS = 2;
    localparam int DROOP_FILTER_NS = 1000;
    localparam int DROOP_FILTER_CYCLES = (DROOP_FILTER_NS * CLK_MHZ + 999) / 1000;
    localparam int PIN_PULSE_NS = 1000;
    localparam int PIN_PULSE_CYCLES = (PIN_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int RELEASE_LONG_TICKS = 65536;
    localparam int RELEASE_SHORT_TICKS = 4096;
    localparam int RELEASE_SYS_CYCLES = 24;
    localparam int SAMPLE_WINDOW_CYCLES = 8;
    localparam int PROTECT_WINDOW_CYCLES = 4;
    localparam logic [7:0] PROTECT_KEY = 8'hD8;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CAUSE = 6'h00;
    localparam logic [5:0] IDX_CTRL = 6'h01;
    localparam logic [5:0] IDX_PROTECT = 6'h02;

    localparam int FLAG_SOFT = 5;
    localparam int FLAG_DEBUG = 4;
    localparam int FLAG_WDOG = 3;
    localparam int FLAG_DROOP = 2;
    localparam int FLAG_PIN = 1;
    localparam int FLAG_POWERUP = 0;
    localparam logic [7:0] FLAGS_MASK = 8'h3F;
    localparam logic [7:0] CAUSE_RESET = 8'h00;
    localparam logic [7:0] CAUSE_POWERUP = 8'h01;
    localparam int CTRL_SOFT_BIT = 0;

    localparam logic [2:0] THRESH_LOWEST = 3'h7;
    localparam logic [2:0] THRESH_RESET = 3'h0;
    localparam int THRESH_TOP_MV = 3000;
    localparam int THRESH_STEP_MV = 200;

    typedef enum logic [1:0] {
        RSC_MODE_RSVD = 2'h0,
        RSC_MODE_SAMPLED = 2'h1,
        RSC_MODE_ENABLED = 2'h2,
        RSC_MODE_DISABLED = 2'h3
    } rsc_droop_mode_t;

    localparam logic [1:0] DELAY_LONG = 2'h0;
    localparam logic [1:0] DELAY_SHORT = 2'h1;
    localparam logic [1:0] DELAY_NONE = 2'h3;

    typedef enum logic [3:0] {
        RSC_ST_HOLD = 4'h1,
        RSC_ST_SLOW = 4'h2,
        RSC_ST_FAST = 4'h4,
        RSC_ST_RUN = 4'h8
    } rsc_state_t;
endpackage

/* File: tb/rsc_source_model.sv */
// Model of the supply monitor, reset pin, watchdog line and debug programmer
`timescale 1ns/100ps
module rsc_source_model (
    input wire logic i_clk,
    output logic o_supply_above_powerup,
    output logic o_supply_below_droop,
    output logic o_reset_pin_n,
    output logic o_watchdog_expire,
    output logic o_debug_reset_req
);
    initial begin
        o_supply_above_powerup = 1'b1;
        o_supply_below_droop = 1'b0;
        o_reset_pin_n = 1'b1;
        o_watchdog_expire = 1'b0;
        o_debug_reset_req = 1'b0;
    end
    // Source index follows the cause flag position
    task automatic fire(input int src, input int len);
        o_supply_above_powerup <= (src != 0);
        o_reset_pin_n <= (src != 1);
        o_supply_below_droop <= (src == 2);
        o_watchdog_expire <= (src == 3);
        o_debug_reset_req <= (src == 4);
        repeat (len) @(posedge i_clk);
        o_supply_above_powerup <= 1'b1;
        o_reset_pin_n <= 1'b1; // Pull-up returns an idle pin high
        o_supply_below_droop <= 1'b0;
        o_watchdog_expire <= 1'b0;
        o_debug_reset_req <= 1'b0;
    endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the reset source controller
`timescale 1ns/100ps
module tb_top;
    logic i_clk = 1'b0, i_reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, dbg_en = 1'b0, prog = 1'b0;
    logic erase = 1'b0, slp = 1'b0;
    logic [1:0] htrans = 2'h0, mode = 2'h2, dly = 2'h3, mode_sl = 2'h3;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, w;
    logic hready, hresp, sys_rst, halt, det_pwr, a_pu, b_dr, pin_n, wdx, dbg, rst_seen = 1'b0;
    logic [2:0] thr = 3'h0, thr_sel;
    logic [11:0] mv;
    int err_total = 0, checks_done = 0, cycles = 0, cause = 0, n = 0;
    int srcs[7] = '{0, 1, 1, 3, 4, 2, 0};
    int lens[7] = '{10, 100, 400, 1, 20, 400, 10};
    always #2 i_clk = ~i_clk;
    rsc_source_model i_src (.i_clk(i_clk), .o_supply_above_powerup(a_pu),
        .o_supply_below_droop(b_dr), .o_reset_pin_n(pin_n), .o_watchdog_expire(wdx),
        .o_debug_reset_req(dbg));
    rsc_controller #(.LP_DIV_CYCLES(20), .RELEASE_LONG_TICKS(4), .RELEASE_SHORT_TICKS(2)) i_dut (
        .i_clk(i_clk), .i_reset(i_reset), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_supply_above_powerup(a_pu), .i_supply_below_droop(b_dr), .i_reset_pin_n(pin_n),
        .i_watchdog_expire(wdx), .i_debug_reset_req(dbg), .i_chip_erase(erase),
        .i_debug_port_enable(dbg_en), .i_programming_mode(prog), .i_deep_sleep(slp),
        .i_fuse_droop_threshold_select(thr), .i_fuse_droop_mode_active(mode),
        .i_fuse_droop_mode_sleep(mode_sl), .i_fuse_release_delay_code(dly),
        .o_system_reset(sys_rst), .o_cpu_halt(halt), .o_droop_detector_power(det_pwr),
        .o_droop_threshold_select(thr_sel), .o_droop_threshold_mv(mv));
    always @(posedge i_clk) begin
        if (sys_rst === 1'b1)
            rst_seen <= 1'b1;
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Single word transfer; caller stands just after a rising edge
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wdat);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, idx, 2'h0};
        @(posedge i_clk);
        while (hready !== 1'b1) @(posedge i_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdat;
        @(posedge i_clk);
        while (hready !== 1'b1) @(posedge i_clk);
        rd = hrdata;
    endtask
    task automatic settle();
        repeat (4) @(posedge i_clk);
        while (sys_rst !== 1'b0 && cycles < 39000) @(posedge i_clk);
        chk(32'(sys_rst), 32'h0);
        @(posedge i_clk);
    endtask
    task automatic read_cause();
        bus(1'b0, rsc_pkg::IDX_CAUSE, 32'h0);
        chk(rd, 32'(cause));
        chk(32'(hresp), 32'h0);
    endtask
    task automatic hit(input int src, input int len, input logic exp_rst);
        rst_seen <= 1'b0;
        i_src.fire(src, len);
        settle();
        chk(32'(rst_seen), 32'(exp_rst));
        if (exp_rst)
            cause = (src == 0) ? 1 : (cause | (1 << src));
        read_cause();
    endtask
    initial begin
        thr <= 3'($urandom(51986));
        repeat (5) @(posedge i_clk);
        i_reset <= 1'b0;
        settle();
        chk(32'(mv), 32'(3000 - 200 * int'(thr)));
        read_cause();
        for (int k = 0; k < 7; k++)
            hit(srcs[k], lens[k], lens[k] != 100);
        w = $urandom;
        bus(1'b1, rsc_pkg::IDX_CAUSE, w);
        cause = cause & ~int'(w[5:0]);
        read_cause();
        bus(1'b1, rsc_pkg::IDX_CAUSE, 32'hFFFFFFFF);
        cause = 0;
        read_cause();
        bus(1'b0, 6'h05, 32'h0);
        chk(rd, 32'h0);
        prog <= 1'b1;
        thr <= ~thr;
        repeat (4) @(posedge i_clk);
        chk(32'(thr_sel), 32'(thr ^ 3'h7));
        prog <= 1'b0;
        repeat (4) @(posedge i_clk);
        chk(32'(thr_sel), 32'(thr));
        mode <= 2'h3;
        dbg_en <= 1'b1;
        repeat (4) @(posedge i_clk);
        chk(32'(thr_sel), 32'h7);
        hit(2, 400, 1'b1);
        dbg_en <= 1'b0;
        slp <= 1'b1;
        mode_sl <= 2'h1;
        dly <= 2'h1;
        repeat (24) @(posedge i_clk);
        n = 0;
        repeat (20) begin
            @(posedge i_clk);
            n += int'(det_pwr);
        end
        chk(32'(n), 32'h8);
        hit(2, 60, 1'b1);
        slp <= 1'b0;
        erase <= 1'b1;
        dly <= 2'h0;
        repeat (4) @(posedge i_clk);
        chk(32'({thr_sel, det_pwr}), 32'hF);
        erase <= 1'b0;
        repeat (4) @(posedge i_clk);
        chk(32'(det_pwr), 32'h0);
        rst_seen <= 1'b0;
        bus(1'b1, rsc_pkg::IDX_CTRL, 32'h1);
        repeat (4) @(posedge i_clk);
        chk(32'(rst_seen), 32'h0);
        bus(1'b1, rsc_pkg::IDX_PROTECT, {24'h0, rsc_pkg::PROTECT_KEY});
        bus(1'b1, rsc_pkg::IDX_CTRL, 32'h1);
        @(posedge i_clk);
        #1;
        chk(32'({halt, sys_rst}), 32'h3);
        @(posedge i_clk);
        settle();
        cause = cause | 32'h20;
        read_cause();
        bus(1'b0, rsc_pkg::IDX_CTRL, 32'h0);
        chk(rd, 32'h0);
        wrap_up();
    end
endmodule

/* File: verilog/rsc_controller.sv */
// Reset source controller: combines reset sources and records the cause
// How it works
// (RQ1) Supply below power-up threshold holds power-up reset
// (RQ2) Disabled droop detector forced on at lowest
// (RQ3) Active droop detector low asserts droop reset
// (RQ4) Droop release goes through the release timeout
// (RQ5) Droop shorter than filter time is ignored unless caught by a sample in sampled mode
// (RQ6) Threshold code 111 is 1.6V, 000 3.0V
// (RQ7) Threshold fuse applied only after programming exit
// (RQ8) Sampled mode powers detector once per tick
// (RQ9) Sampled droop switches detector to continuous
// (RQ10) Active fuse when awake, sleep fuse otherwise
// (RQ11) Mode codes: reserved, sampled, enabled, disabled
// (RQ12) Pin low past minimum pulse holds reset
// (RQ13) Watchdog reset lasts one to two periods
// (RQ14) Software reset issued within two clocks
// (RQ15) CPU halted from request until reset
// (RQ16) Debug reset comes only from debug pin
// (RQ17) Six sticky cause flags in status register
// (RQ18) Non-power flags cleared by power-up or W1C
// (RQ19) Power-up flag set by power-up, W1C only
// (RQ20) Control bit 0 requests reset, self-clears
// (RQ21) Control bit writable only after unlock key
// (RQ22) Reset held while any source is active
// (RQ23) Release delay from fuse, then 24 clocks
// (RQ24) New request restarts the release sequence
// (RQ25) Reserved bits read zero, ignore writes
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/100ps
module rsc_controller #(
    parameter int unsigned LP_DIV_CYCLES = rsc_pkg::LP_DIV_CYCLES,
    parameter int unsigned RELEASE_LONG_TICKS = rsc_pkg::RELEASE_LONG_TICKS,
    parameter int unsigned RELEASE_SHORT_TICKS = rsc_pkg::RELEASE_SHORT_TICKS
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_supply_above_powerup,
    input wire logic i_supply_below_droop,
    input wire logic i_reset_pin_n,
    input wire logic i_watchdog_expire,
    input wire logic i_debug_reset_req,
    input wire logic i_chip_erase,
    input wire logic i_debug_port_enable,
    input wire logic i_programming_mode,
    input wire logic i_deep_sleep,
    input wire logic [2:0] i_fuse_droop_threshold_select,
    input wire logic [1:0] i_fuse_droop_mode_active,
    input wire logic [1:0] i_fuse_droop_mode_sleep,
    input wire logic [1:0] i_fuse_release_delay_code,
    output logic o_system_reset,
    output logic o_cpu_halt,
    output logic o_droop_detector_power,
    output logic [2:0] o_droop_threshold_select,
    output logic [11:0] o_droop_threshold_mv
);
    localparam logic [7:0] FAST_LAST = 8'(rsc_pkg::FAST_DIV_CYCLES - 1);
    localparam logic [3:0] SAMPLE_LEN = 4'(rsc_pkg::SAMPLE_WINDOW_CYCLES);
    localparam logic [2:0] UNLOCK_LEN = 3'(rsc_pkg::PROTECT_WINDOW_CYCLES);

    // Slow rate enables
    logic [31:0] lp_div_reg;
    logic lp_tick_reg;
    logic [7:0] fast_div_reg;
    logic fast_tick_reg;

    always_ff @(posedge i_clk) begin
        if (i_reset || lp_div_reg == LP_DIV_CYCLES - 1) begin
            lp_div_reg <= 32'h0;
            lp_tick_reg <= !i_reset;
        end else begin
            lp_div_reg <= lp_div_reg + 32'h1;
            lp_tick_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset || fast_div_reg == FAST_LAST) begin
            fast_div_reg <= 8'h0;
            fast_tick_reg <= !i_reset;
        end else begin
            fast_div_reg <= fast_div_reg + 8'h1;
            fast_tick_reg <= 1'b0;
        end
    end

    // Two-stage synchronisers: [2] debug, [1] watchdog, [0] power-up
    logic [2:0] async_in;
    logic [2:0] meta_reg;
    logic [2:0] sync_reg;
    assign async_in = {i_debug_reset_req, i_watchdog_expire, !i_supply_above_powerup};

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta_reg <= 3'h0;
            sync_reg <= 3'h0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    logic powerup_src;
    logic debug_src;
    assign powerup_src = sync_reg[0]; // [RQ1]
    assign debug_src = sync_reg[2]; // [RQ16]

    // Droop mode selection
    rsc_pkg::rsc_droop_mode_t mode_sel;
    logic forced_on;
    logic cont_mode;
    logic sampled_mode;
    logic promoted_reg;
    logic [3:0] sample_cnt_reg;
    logic droop_level;
    logic droop_filtered;
    logic droop_src;

    always_comb begin
        mode_sel = rsc_pkg::rsc_droop_mode_t'(i_deep_sleep ? i_fuse_droop_mode_sleep
                                                           : i_fuse_droop_mode_active); // [RQ10]
    end

    // Reserved mode code is treated as disabled
    assign forced_on = (mode_sel == rsc_pkg::RSC_MODE_DISABLED
                        || mode_sel == rsc_pkg::RSC_MODE_RSVD)
                       && (i_chip_erase || i_debug_port_enable); // [RQ2] [RQ11]
    assign cont_mode = mode_sel == rsc_pkg::RSC_MODE_ENABLED || forced_on
                       || promoted_reg; // [RQ11]
    assign sampled_mode = mode_sel == rsc_pkg::RSC_MODE_SAMPLED && !cont_mode; // [RQ11]

    rsc_sync_filter #(
        .FILTER_CYCLES(rsc_pkg::DROOP_FILTER_CYCLES)
    ) u_droop_filter (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_async(i_supply_below_droop),
        .i_enable(cont_mode),
        .o_level(droop_level),
        .o_filtered(droop_filtered)
    ); // [RQ5]

    // Sample window opens on each slow tick; detector is off otherwise
    always_ff @(posedge i_clk) begin
        if (i_reset || !sampled_mode) begin
            sample_cnt_reg <= 4'h0;
        end else if (lp_tick_reg) begin
            sample_cnt_reg <= SAMPLE_LEN; // [RQ8]
        end else if (sample_cnt_reg != 4'h0) begin
            sample_cnt_reg <= sample_cnt_reg - 4'h1;
        end
    end

    // Sample taken in the last powered cycle of the window
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            promoted_reg <= 1'b0;
        end else if (sampled_mode && sample_cnt_reg == 4'h1 && droop_level) begin
            promoted_reg <= 1'b1; // [RQ9]
        end else if (promoted_reg && !droop_level) begin
            promoted_reg <= 1'b0; // [RQ9]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_droop_detector_power <= 1'b0;
        end else begin
            o_droop_detector_power <= cont_mode || sample_cnt_reg != 4'h0; // [RQ8]
        end
    end

    assign droop_src = (cont_mode && droop_filtered) || promoted_reg; // [RQ3] [RQ9]

    // Threshold fuse is caught once after reset, then only on leaving programming
    logic thr_loaded_reg;
    logic prog_prev_reg;
    logic [2:0] thr_reg;
    logic [2:0] thr_sel;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            thr_loaded_reg <= 1'b0;
            prog_prev_reg <= 1'b0;
            thr_reg <= rsc_pkg::THRESH_RESET;
        end else begin
            prog_prev_reg <= i_programming_mode;
            if (!thr_loaded_reg || (prog_prev_reg && !i_programming_mode)) begin
                thr_reg <= i_fuse_droop_threshold_select; // [RQ7]
                thr_loaded_reg <= 1'b1;
            end
        end
    end

    assign thr_sel = forced_on ? rsc_pkg::THRESH_LOWEST : thr_reg; // [RQ2]

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_droop_threshold_select <= rsc_pkg::THRESH_RESET;
            o_droop_threshold_mv <= 12'(rsc_pkg::THRESH_TOP_MV);
        end else begin
            o_droop_threshold_select <= thr_sel;
            o_droop_threshold_mv <= 12'(rsc_pkg::THRESH_TOP_MV
                                        - rsc_pkg::THRESH_STEP_MV * int'(thr_sel)); // [RQ6]
        end
    end

    // External pin
    logic pin_level;
    logic pin_src;

    rsc_sync_filter #(
        .FILTER_CYCLES(rsc_pkg::PIN_PULSE_CYCLES)
    ) u_pin_filter (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_async(!i_reset_pin_n),
        .i_enable(1'b1),
        .o_level(pin_level),
        .o_filtered(pin_src)
    ); // [RQ12]

    // Watchdog expiry stretched to one or two fast oscillator periods
    logic wd_prev_reg;
    logic wd_hold_reg;
    logic [1:0] wd_ticks_reg;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            wd_prev_reg <= 1'b0;
            wd_hold_reg <= 1'b0;
            wd_ticks_reg <= 2'h0;
        end else begin
            wd_prev_reg <= sync_reg[1];
            if (sync_reg[1] && !wd_prev_reg) begin
                wd_hold_reg <= 1'b1; // [RQ13]
                wd_ticks_reg <= 2'h0;
            end else if (wd_hold_reg && fast_tick_reg) begin
                wd_ticks_reg <= wd_ticks_reg + 2'h1;
                if (wd_ticks_reg == 2'(rsc_pkg::WDOG_HOLD_TICKS - 1)) begin
                    wd_hold_reg <= 1'b0; // [RQ13]
                end
            end
        end
    end

    // Length of the current watchdog hold, kept for the length check
    logic [8:0] wd_len_reg;

    always_ff @(posedge i_clk) begin
        if (i_reset || !wd_hold_reg) begin
            wd_len_reg <= 9'h000;
        end else begin
            wd_len_reg <= wd_len_reg + 9'h001;
        end
    end

    // Register bus, zero wait states
    logic soft_bit_reg;
    logic [7:0] cause_reg;
    logic [2:0] unlock_cnt_reg;
    logic wr_pend_reg;
    logic [5:0] wr_idx_reg;
    logic addr_ok;
    logic wr_cause;
    logic wr_ctrl;
    logic wr_key;
    logic [31:0] rd_mux;

    assign addr_ok = i_hsel && i_htrans[1] && i_hready;
    assign wr_cause = wr_pend_reg && wr_idx_reg == rsc_pkg::IDX_CAUSE;
    assign wr_ctrl = wr_pend_reg && wr_idx_reg == rsc_pkg::IDX_CTRL;
    assign wr_key = wr_pend_reg && wr_idx_reg == rsc_pkg::IDX_PROTECT
                    && i_hwdata[7:0] == rsc_pkg::PROTECT_KEY;

    always_comb begin
        rd_mux = 32'h0; // [RQ25]
        if (i_haddr[31:8] == 24'h0) begin
            unique case (i_haddr[7:2])
                rsc_pkg::IDX_CAUSE: rd_mux = {24'h0, cause_reg & rsc_pkg::FLAGS_MASK};
                rsc_pkg::IDX_CTRL: rd_mux = {31'h0, soft_bit_reg};
                rsc_pkg::IDX_PROTECT: rd_mux = {31'h0, unlock_cnt_reg != 3'h0};
                default: rd_mux = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 6'h0;
            o_hrdata <= 32'h0;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            wr_pend_reg <= addr_ok && i_hwrite && i_haddr[31:8] == 24'h0;
            wr_idx_reg <= i_haddr[7:2];
            o_hrdata <= (addr_ok && !i_hwrite) ? rd_mux : 32'h0;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

    // Unlock window; any control write closes it
    always_ff @(posedge i_clk) begin
        if (i_reset || wr_ctrl) begin
            unlock_cnt_reg <= 3'h0;
        end else if (wr_key) begin
            unlock_cnt_reg <= UNLOCK_LEN; // [RQ21]
        end else if (unlock_cnt_reg != 3'h0) begin
            unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
        end
    end

    // Release sequencer
    rsc_pkg::rsc_state_t state_reg;
    logic [31:0] rel_cnt_reg;
    logic [31:0] slow_target;
    logic any_src;
    logic soft_issue;

    assign any_src = powerup_src || droop_src || pin_src || wd_hold_reg
                     || debug_src || soft_bit_reg; // [RQ22]
    assign soft_issue = soft_bit_reg && o_system_reset;
    // Reserved delay code takes the longest delay
    assign slow_target = i_fuse_release_delay_code == rsc_pkg::DELAY_SHORT
                         ? RELEASE_SHORT_TICKS : RELEASE_LONG_TICKS; // [RQ23]

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_reg <= rsc_pkg::RSC_ST_HOLD;
            rel_cnt_reg <= 32'h0;
        end else if (any_src) begin
            state_reg <= rsc_pkg::RSC_ST_HOLD; // [RQ24] [RQ22] [RQ4]
            rel_cnt_reg <= 32'h0;
        end else begin
            unique case (state_reg)
                rsc_pkg::RSC_ST_HOLD: begin
                    rel_cnt_reg <= 32'h0;
                    state_reg <= i_fuse_release_delay_code == rsc_pkg::DELAY_NONE
                                 ? rsc_pkg::RSC_ST_FAST : rsc_pkg::RSC_ST_SLOW; // [RQ23]
                end
                rsc_pkg::RSC_ST_SLOW: begin
                    if (lp_tick_reg) begin
                        if (rel_cnt_reg == slow_target - 32'h1) begin
                            rel_cnt_reg <= 32'h0;
                            state_reg <= rsc_pkg::RSC_ST_FAST; // [RQ23]
                        end else begin
                            rel_cnt_reg <= rel_cnt_reg + 32'h1;
                        end
                    end
                end
                rsc_pkg::RSC_ST_FAST: begin
                    if (rel_cnt_reg == 32'(rsc_pkg::RELEASE_SYS_CYCLES - 1)) begin
                        state_reg <= rsc_pkg::RSC_ST_RUN; // [RQ23]
                    end else begin
                        rel_cnt_reg <= rel_cnt_reg + 32'h1;
                    end
                end
                rsc_pkg::RSC_ST_RUN: rel_cnt_reg <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_system_reset <= 1'b1;
        end else begin
            o_system_reset <= any_src || state_reg != rsc_pkg::RSC_ST_RUN; // [RQ22] [RQ14]
        end
    end

    // Software reset bit doubles as the CPU halt so no instruction slips through
    always_ff @(posedge i_clk) begin
        if (i_reset || soft_issue) begin
            soft_bit_reg <= 1'b0; // [RQ20]
            o_cpu_halt <= 1'b0;
        end else if (wr_ctrl && unlock_cnt_reg != 3'h0
                     && i_hwdata[rsc_pkg::CTRL_SOFT_BIT]) begin
            soft_bit_reg <= 1'b1; // [RQ20] [RQ21]
            o_cpu_halt <= 1'b1; // [RQ15]
        end
    end

    // Sticky cause flags; a set wins over a same-cycle clear
    logic [7:0] flag_set;
    logic [7:0] flag_clr;

    always_comb begin
        flag_set = 8'h0;
        flag_set[rsc_pkg::FLAG_SOFT] = soft_issue;
        flag_set[rsc_pkg::FLAG_DEBUG] = debug_src;
        flag_set[rsc_pkg::FLAG_WDOG] = wd_hold_reg;
        flag_set[rsc_pkg::FLAG_DROOP] = droop_src;
        flag_set[rsc_pkg::FLAG_PIN] = pin_src;
        flag_set[rsc_pkg::FLAG_POWERUP] = powerup_src;
        flag_clr = wr_cause ? i_hwdata[7:0] & rsc_pkg::FLAGS_MASK : 8'h0;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cause_reg <= rsc_pkg::CAUSE_RESET;
        end else if (powerup_src) begin
            cause_reg <= rsc_pkg::CAUSE_POWERUP; // [RQ18] [RQ19]
        end else begin
            cause_reg <= ((cause_reg & ~flag_clr) | flag_set)
                         & rsc_pkg::FLAGS_MASK; // [RQ17] [RQ18] [RQ25]
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    sequence s_unlocked_soft_write;
        wr_ctrl && unlock_cnt_reg != 3'h0 && i_hwdata[0] && !soft_bit_reg;
    endsequence

    sequence s_fast_done;
        state_reg == rsc_pkg::RSC_ST_FAST
        && rel_cnt_reg == 32'(rsc_pkg::RELEASE_SYS_CYCLES - 1) && !any_src;
    endsequence

    a_soft_reset_fast: assert property ( // [RQ14]
        s_unlocked_soft_write |=> o_cpu_halt ##1 o_system_reset)
        else $error("software reset not issued in two clocks");

    a_locked_write_ignored: assert property ( // [RQ21]
        wr_ctrl && unlock_cnt_reg == 3'h0 && !soft_bit_reg |=> !soft_bit_reg)
        else $error("control write without unlock took effect");

    a_halt_until_reset: assert property ( // [RQ15]
        o_cpu_halt && !o_system_reset |=> o_cpu_halt)
        else $error("cpu halt dropped before reset issued");

    a_hold_while_source: assert property ( // [RQ22]
        any_src |=> o_system_reset ##1 o_system_reset)
        else $error("reset released while a source is active");

    a_fast_stage_len: assert property ( // [RQ23]
        s_fast_done ##1 !any_src |-> state_reg == rsc_pkg::RSC_ST_RUN ##1 !o_system_reset)
        else $error("release after wrong system clock count");

    a_restart_on_request: assert property ( // [RQ24]
        any_src && state_reg != rsc_pkg::RSC_ST_HOLD |=> state_reg == rsc_pkg::RSC_ST_HOLD)
        else $error("release sequence not restarted");

    a_forced_lowest: assert property ( // [RQ2]
        forced_on |=> o_droop_threshold_select == 3'h7 && o_droop_detector_power)
        else $error("forced detector not at lowest level");

    a_threshold_frozen: assert property ( // [RQ7]
        thr_loaded_reg && i_programming_mode |=> $stable(thr_reg))
        else $error("threshold changed during programming");

    a_watchdog_hold: assert property ( // [RQ13]
        $fell(wd_hold_reg) |-> wd_len_reg >= 9'h07D && wd_len_reg <= 9'h0FA)
        else $error("watchdog reset length out of range");

    a_sampled_off: assert property ( // [RQ8]
        !cont_mode && sample_cnt_reg == 4'h0 |=> !o_droop_detector_power)
        else $error("detector powered between samples");

    a_pin_flag: assert property ( // [RQ17]
        pin_src && !powerup_src |=> cause_reg[1])
        else $error("pin reset flag not set");

    a_powerup_clears: assert property ( // [RQ19]
        powerup_src |=> cause_reg == 8'h01)
        else $error("power-up did not reset cause flags");
endmodule

/* File: verilog/rsc_sync_filter.sv */
// Synchroniser with a persistence filter for one asynchronous condition
`timescale 1ns/100ps
module rsc_sync_filter #(
    parameter int unsigned FILTER_CYCLES = 4
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_async,
    input wire logic i_enable,
    output logic o_level,
    output logic o_filtered
);
    localparam int W = $clog2(FILTER_CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(FILTER_CYCLES);

    logic meta_reg;
    logic [W-1:0] cnt_reg;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta_reg <= 1'b0;
            o_level <= 1'b0;
        end else begin
            meta_reg <= i_async;
            o_level <= meta_reg;
        end
    end

    // Short dips restart the count and never reach the output
    always_ff @(posedge i_clk) begin
        if (i_reset || !i_enable || !o_level) begin
            cnt_reg <= '0;
            o_filtered <= 1'b0;
        end else if (cnt_reg != LAST) begin
            cnt_reg <= cnt_reg + W'(1);
        end else begin
            o_filtered <= 1'b1;
        end
    end
endmodule
